// *** include/fswds_pkg.sv ***
// Package of constants and carrier types for the failsafe watchdog supervisor.
// Behaviour
// - Without clears: warning after one timeout, reset after two; reset held.
// - Default timeout interval and power-on reset delay are both 10 ms.
// - Power-on sequence needs supply good and input above upper threshold.
// - Input below middle threshold drives the power-fail warning active.
// - Input below lowest threshold drives system reset active.
// - Falling edge on timer clear zeroes timer and returns warning high.
// - Warning toggles each interval, low first; reset at end of low phase.
// - Clears ignored in power-on delay; watchdog runs after reset release.
// - Drop below lowest forces reset and power fail low, warning disabled.
`default_nettype none
package fswds_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS   = 50;
	localparam int unsigned TIMEOUT_MS      = 10;
	localparam int unsigned TIMEOUT_CYCLES  =
		(TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned CLR_PULSE_NS    = 150;
	localparam int unsigned CLR_PULSE_CYC   =
		(CLR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W           = 24;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		FSWDS_OFF  = 3'b000,
		FSWDS_POR  = 3'b001,
		FSWDS_RUN  = 3'b011,
		FSWDS_WARN = 3'b010,
		FSWDS_HALT = 3'b110
	} fswds_state_t;

	typedef struct packed {
		logic supply_good;
		logic above_upper;
		logic above_middle;
		logic above_lowest;
		logic clear_n;
	} fswds_sense_t;

	typedef struct packed {
		logic timeout_warning_n;
		logic power_fail_n;
		logic system_reset_n;
	} fswds_outs_t;
endpackage : fswds_pkg
`default_nettype wire

// *** logic/fswds_sync.sv ***
// Two-flip-flop synchroniser for one level.
`default_nettype none
module fswds_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_r;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r <= RESET_VAL;
			q_out  <= RESET_VAL;
		end else if (ce_in) begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule : fswds_sync
`default_nettype wire

// *** logic/fswds_top.sv ***
// Failsafe watchdog with supply supervisor, device side.
`default_nettype none
module fswds_top #(
	parameter int unsigned TIMEOUT_CYC = fswds_pkg::TIMEOUT_CYCLES
) (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic clk_en_in,
	input  wire logic supply_good_in,
	input  wire logic above_upper_in,
	input  wire logic above_middle_in,
	input  wire logic above_lowest_in,
	input  wire logic timer_clear_n_in,
	output logic      timeout_warning_n_out,
	output logic      power_fail_n_out,
	output logic      system_reset_n_out
);
	// ************************************************************
	// Input synchronisers
	// ************************************************************
	fswds_pkg::fswds_sense_t raw_s;
	fswds_pkg::fswds_sense_t sync_s;

	assign raw_s = '{supply_good  : supply_good_in,
	                 above_upper  : above_upper_in,
	                 above_middle : above_middle_in,
	                 above_lowest : above_lowest_in,
	                 clear_n      : timer_clear_n_in};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			fswds_sync #(.RESET_VAL(gi == 0)) u_sync (
				.clk_in (ref_clk_in),
				.rst_in (rst_in),
				.ce_in  (clk_en_in),
				.d_in   (raw_s[gi]),
				.q_out  (sync_s[gi])
			);
		end
	endgenerate

	// ************************************************************
	// Clear edge detect
	// ************************************************************
	logic clear_d_r;
	logic clear_ev;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			clear_d_r <= 1'b1;
		end else if (clk_en_in) begin
			clear_d_r <= sync_s.clear_n;
		end
	end

	// Falling edge of the synchronised clear, a 150 ns low pulse spans
	// at least CLR_PULSE_CYC samples so it is seen.
	assign clear_ev = clear_d_r & ~sync_s.clear_n;

	// ************************************************************
	// Timer and state machine
	// ************************************************************
	fswds_pkg::fswds_state_t state_r;
	fswds_pkg::fswds_state_t state_nxt;
	logic [fswds_pkg::CNT_W-1:0] cnt_r;
	logic [fswds_pkg::CNT_W-1:0] cnt_nxt;
	logic                        expire;
	logic                        restart;

	assign expire = (cnt_r == fswds_pkg::CNT_W'(TIMEOUT_CYC - 1));

	always_comb begin
		state_nxt = state_r;
		restart   = 1'b0;
		case (state_r)
			fswds_pkg::FSWDS_OFF: begin
				if (sync_s.supply_good && sync_s.above_upper) begin
					state_nxt = fswds_pkg::FSWDS_POR;
					restart   = 1'b1;
				end
			end
			fswds_pkg::FSWDS_POR: begin
				// Clears have no effect here.
				if (expire) begin
					state_nxt = fswds_pkg::FSWDS_RUN;
					restart   = 1'b1;
				end
			end
			fswds_pkg::FSWDS_RUN: begin
				if (clear_ev) begin
					restart = 1'b1;
				end else if (expire) begin
					state_nxt = fswds_pkg::FSWDS_WARN;
					restart   = 1'b1;
				end
			end
			fswds_pkg::FSWDS_WARN: begin
				if (clear_ev) begin
					state_nxt = fswds_pkg::FSWDS_RUN;
					restart   = 1'b1;
				end else if (expire) begin
					state_nxt = fswds_pkg::FSWDS_HALT;
					restart   = 1'b1;
				end
			end
			fswds_pkg::FSWDS_HALT: begin
				if (clear_ev) begin
					state_nxt = fswds_pkg::FSWDS_RUN;
					restart   = 1'b1;
				end else if (expire) begin
					restart = 1'b1;
				end
			end
			default: begin
				state_nxt = fswds_pkg::FSWDS_OFF;
			end
		endcase
		// Loss of supply or a drop below the lowest threshold wins.
		if (!sync_s.supply_good ||
		    (state_r != fswds_pkg::FSWDS_OFF && !sync_s.above_lowest)) begin
			state_nxt = fswds_pkg::FSWDS_OFF;
			restart   = 1'b1;
		end
	end

	always_comb begin
		if (restart) begin
			cnt_nxt = '0;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= fswds_pkg::FSWDS_OFF;
		end else if (clk_en_in) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= '0;
		end else if (clk_en_in) begin
			cnt_r <= cnt_nxt;
		end
	end

	// ************************************************************
	// Square wave phase in halt
	// ************************************************************
	logic phase_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase_r <= 1'b0;
		end else if (clk_en_in) begin
			if (state_nxt != fswds_pkg::FSWDS_HALT) begin
				phase_r <= 1'b0;
			end else if (state_r == fswds_pkg::FSWDS_WARN) begin
				phase_r <= 1'b1;
			end else if (expire) begin
				phase_r <= ~phase_r;
			end
		end
	end

	// ************************************************************
	// Power-fail latch
	// ************************************************************
	logic save_ok_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			save_ok_r <= 1'b0;
		end else if (clk_en_in) begin
			if (!sync_s.supply_good || !sync_s.above_middle) begin
				save_ok_r <= 1'b0;
			end else if (sync_s.above_upper) begin
				save_ok_r <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			timeout_warning_n_out <= 1'b1;
			power_fail_n_out      <= 1'b0;
			system_reset_n_out    <= 1'b0;
		end else if (clk_en_in) begin
			case (state_nxt)
				fswds_pkg::FSWDS_WARN: begin
					timeout_warning_n_out <= 1'b0;
					system_reset_n_out    <= 1'b1;
				end
				fswds_pkg::FSWDS_HALT: begin
					timeout_warning_n_out <= phase_r ^ expire;
					system_reset_n_out    <= 1'b0;
				end
				fswds_pkg::FSWDS_RUN: begin
					timeout_warning_n_out <= 1'b1;
					system_reset_n_out    <= 1'b1;
				end
				default: begin
					timeout_warning_n_out <= 1'b1;
					system_reset_n_out    <= 1'b0;
				end
			endcase
			power_fail_n_out <= save_ok_r && sync_s.above_middle &&
				state_nxt != fswds_pkg::FSWDS_OFF;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	lowest_forces_reset_a: assert property (
		clk_en_in [*2] ##0 (clk_en_in && !sync_s.above_lowest)
		|=> !system_reset_n_out)
		else $error("reset not forced below lowest threshold");
	lowest_forces_save_a: assert property (
		(clk_en_in && !sync_s.above_lowest) |=> !power_fail_n_out)
		else $error("power fail warning not forced low");
	middle_save_low_a: assert property (
		(clk_en_in && !sync_s.above_middle) |=> !power_fail_n_out)
		else $error("power fail warning not active below middle");
	clear_warn_high_a: assert property (
		(clk_en_in && clear_ev && sync_s.supply_good && sync_s.above_lowest
		 && state_r != fswds_pkg::FSWDS_OFF
		 && state_r != fswds_pkg::FSWDS_POR)
		|=> timeout_warning_n_out && cnt_r == '0)
		else $error("clear did not restore timer");
	por_ignores_clear_a: assert property (
		(clk_en_in && state_r == fswds_pkg::FSWDS_POR && !expire
		 && sync_s.supply_good && sync_s.above_lowest)
		|=> state_r == fswds_pkg::FSWDS_POR && !system_reset_n_out)
		else $error("power on delay disturbed");
	start_needs_both_a: assert property (
		(state_r == fswds_pkg::FSWDS_OFF && clk_en_in
		 && !(sync_s.supply_good && sync_s.above_upper))
		|=> state_r == fswds_pkg::FSWDS_OFF)
		else $error("power on started without conditions");
	warn_on_expire_a: assert property (
		(clk_en_in && state_r == fswds_pkg::FSWDS_RUN && expire && !clear_ev
		 && sync_s.supply_good && sync_s.above_lowest)
		|=> !timeout_warning_n_out && system_reset_n_out)
		else $error("timeout warning not raised");
	reset_after_warn_a: assert property (
		(clk_en_in && state_r == fswds_pkg::FSWDS_WARN && expire && !clear_ev
		 && sync_s.supply_good && sync_s.above_lowest)
		|=> !system_reset_n_out && timeout_warning_n_out)
		else $error("reset not asserted after low phase");
	sync_two_stage_a: assert property (
		clk_en_in [*2] |=> sync_s.clear_n == $past(timer_clear_n_in, 2))
		else $error("synchroniser depth wrong");

	enter_run_c: cover property (state_r == fswds_pkg::FSWDS_POR
		##1 state_r == fswds_pkg::FSWDS_RUN);
	enter_warn_c: cover property (state_r == fswds_pkg::FSWDS_WARN);
	enter_halt_c: cover property (state_r == fswds_pkg::FSWDS_HALT);
	halt_clear_c: cover property (state_r == fswds_pkg::FSWDS_HALT
		&& clear_ev);
endmodule : fswds_top
`default_nettype wire

// *** verif/fswds_host_model.sv ***
// Host model that issues timer clear pulses on request or periodically.
`default_nettype none
module fswds_host_model (
	input  wire logic       clk_in,
	input  wire logic       run_in,
	input  wire logic       pulse_in,
	input  wire logic [7:0] gap_in,
	output logic            clear_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned wait_r;
	int unsigned low_r;
	initial begin
		clear_n_out = 1'b1;
		wait_r = 0;
		low_r = 0;
	end
	// ************************************************************
	// Each pulse stays low three cycles, then the line idles high.
	// ************************************************************
	always @(negedge clk_in) begin
		if (low_r != 0) begin
			low_r <= low_r - 1;
			clear_n_out <= (low_r == 1);
		end else if (pulse_in || (run_in && wait_r >= gap_in)) begin
			low_r <= 3;
			clear_n_out <= 1'b0;
			wait_r <= 0;
		end else begin
			wait_r <= wait_r + 1;
		end
	end
endmodule : fswds_host_model
`default_nettype wire

// *** verif/fswds_tb_top.sv ***
// Self-checking bench for the failsafe watchdog supervisor.
`default_nettype none
module fswds_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int T = 20;
	logic       clk, rst, ce, sg, up, mid, low, run, pls;
	logic [7:0] gap;
	wire logic  clr_n;
	logic       wrn_n, pf_n, sr_n;
	int         bad_count, cmp_count, cyc, n;
	fswds_top #(.TIMEOUT_CYC(T)) dut_u (.ref_clk_in(clk), .rst_in(rst),
		.clk_en_in(ce), .supply_good_in(sg), .above_upper_in(up),
		.above_middle_in(mid), .above_lowest_in(low),
		.timer_clear_n_in(clr_n), .timeout_warning_n_out(wrn_n),
		.power_fail_n_out(pf_n), .system_reset_n_out(sr_n));
	fswds_host_model host_u (.clk_in(clk), .run_in(run), .pulse_in(pls),
		.gap_in(gap), .clear_n_out(clr_n));
	// ************************************************************
	// Clock, watchdog of the run, helpers.
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			conclude();
		end
	end
	function automatic logic out_of(int i);
		return (i == 0) ? wrn_n : (i == 1) ? pf_n : sr_n;
	endfunction : out_of
	function automatic int lo_of(int k);
		return k * T - 2;
	endfunction : lo_of
	function automatic int hi_of(int k);
		return k * T + 3;
	endfunction : hi_of
	task automatic wait_for(input int i, input logic v, input int lim);
		n = 0;
		while (out_of(i) !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_for
	task automatic chk(input string s, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", s, e, g);
		end
	endtask : chk
	task automatic chk_n(input string s, input int lo, input int hi);
		cmp_count++;
		if (n < lo || n > hi) begin
			bad_count++;
			$display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, n);
		end
	endtask : chk_n
	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask : tick
	task automatic pulse();
		pls <= 1'b1;
		@(negedge clk);
		pls <= 1'b0;
	endtask : pulse
	task automatic vin(input logic s, input logic u, input logic m,
		input logic l);
		sg = s;
		up = u;
		mid = m;
		low = l;
	endtask : vin
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		vin(1'b0, 1'b0, 1'b0, 1'b0);
		{run, pls, gap} = 10'h006;
		{bad_count, cmp_count, cyc, n} = '0;
		void'($urandom(32'h4244));
		tick(8);
		rst = 1'b0;
		chk("reset_out", 1'b0, sr_n);
		vin(1'b0, 1'b1, 1'b1, 1'b1);
		tick(3 * T);
		chk("reset_out", 1'b0, sr_n);
		chk("power_fail", 1'b0, pf_n);
		$display("test supply_gate finished");
		vin(1'b1, 1'b1, 1'b1, 1'b1);
		wait_for(1, 1'b1, 8);
		chk_n("por_start", 2, 5);
		pulse();
		wait_for(2, 1'b1, 2 * T);
		chk_n("por_delay", lo_of(1), hi_of(1));
		wait_for(0, 1'b0, 2 * T);
		chk_n("first_warn", lo_of(1), hi_of(1));
		wait_for(0, 1'b1, 2 * T);
		chk_n("halt_entry", lo_of(1), hi_of(1));
		chk("reset_out", 1'b0, sr_n);
		wait_for(0, 1'b0, 2 * T);
		chk_n("square_wave", lo_of(1), hi_of(1));
		chk("reset_out", 1'b0, sr_n);
		$display("test timeout finished");
		pulse();
		wait_for(2, 1'b1, 10);
		chk_n("clear_delay", 2, 7);
		chk("warning", 1'b1, wrn_n);
		run <= 1'b1;
		n = 0;
		repeat (10) begin
			gap <= 8'(3 + $urandom % 8);
			repeat (T) begin
				@(negedge clk);
				if (wrn_n !== 1'b1) n++;
			end
		end
		chk_n("warn_lows", 0, 0);
		$display("test clearing finished");
		vin(1'b1, 1'b0, 1'b0, 1'b1);
		wait_for(1, 1'b0, 8);
		chk_n("pf_fall", 2, 5);
		chk("reset_out", 1'b1, sr_n);
		vin(1'b1, 1'b0, 1'b1, 1'b1);
		tick(6);
		chk("power_fail", 1'b0, pf_n);
		vin(1'b1, 1'b1, 1'b1, 1'b1);
		wait_for(1, 1'b1, 8);
		chk_n("pf_rise", 2, 5);
		vin(1'b1, 1'b0, 1'b0, 1'b0);
		wait_for(2, 1'b0, 8);
		chk_n("drop_reset", 2, 5);
		chk("power_fail", 1'b0, pf_n);
		chk("warning", 1'b1, wrn_n);
		tick(2 * T);
		chk("reset_out", 1'b0, sr_n);
		vin(1'b1, 1'b1, 1'b1, 1'b1);
		wait_for(1, 1'b1, 8);
		// A low clock enable must stop the power-on timer where it stands.
		ce = 1'b0;
		tick(2 * T);
		chk("frozen_reset", 1'b0, sr_n);
		ce = 1'b1;
		wait_for(2, 1'b1, 2 * T);
		chk_n("restart", lo_of(1), hi_of(1));
		$display("test voltage finished");
		conclude();
	end
endmodule : fswds_tb_top
`default_nettype wire
